// ---- dlpr_pkg.sv ----
// Shared constants and carriers of the dual-link pixel receiver
package dlpr_pkg;

  // Serial word width of one lane and the common counter width
  localparam int LANE_W = 7;
  localparam int CNT_W  = 11;

  // Lane 2 slot that carries the data-enable copy
  localparam int LANE_DE_BIT = 6;

  // Line and frame geometry checked on the link
  localparam logic [10:0] HACTIVE    = 11'h280; // 640 cycles
  localparam logic [10:0] HTOTAL_MIN = 11'h2E4; // 740 cycles
  localparam logic [10:0] HTOTAL_MAX = 11'h3C0; // 960 cycles
  localparam logic [10:0] HBLANK_MAX = HTOTAL_MAX - HACTIVE;
  localparam logic [10:0] VACTIVE    = 11'h400; // 1024 lines
  localparam logic [10:0] CNT_MAX    = 11'h7FF;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERR    = 8'h08;
  localparam logic [7:0] ADDR_LINE   = 8'h0C;
  localparam logic [7:0] ADDR_FRAME  = 8'h10;
  localparam logic [7:0] ADDR_FCOUNT = 8'h14;

  // Control fields and reset value
  localparam int         CTRL_EN_BIT    = 0;
  localparam int         CTRL_BLACK_BIT = 1;
  localparam logic [1:0] CTRL_RESET     = 2'h1;

  // Status fields
  localparam int STAT_LAMP_BIT  = 0;
  localparam int STAT_ALIVE_BIT = 1;
  localparam int STAT_MAP_BIT   = 2;

  // Error fields
  localparam int ERR_H_BIT = 0; // active cycles per line
  localparam int ERR_T_BIT = 1; // total line length
  localparam int ERR_V_BIT = 2; // active lines per frame
  localparam int ERR_M_BIT = 3; // data-enable copies differ

  // Even clock activity monitor
  localparam int         EVEN_DIV_W = 5;
  localparam logic [7:0] ALIVE_WIN  = 8'hFF;

  // One pixel colour
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } dlpr_rgb_t;

  // The four lane words of one link
  typedef struct packed {
    logic [LANE_W-1:0] lane3;
    logic [LANE_W-1:0] lane2;
    logic [LANE_W-1:0] lane1;
    logic [LANE_W-1:0] lane0;
  } dlpr_lanes_t;

  // Per-frame summary passed to the register side
  typedef struct packed {
    logic [CNT_W-1:0] line_px;
    logic [CNT_W-1:0] frame_lines;
    logic [3:0]       errs;
  } dlpr_summary_t;

endpackage

// ---- dlpr_receiver.sv ----
`timescale 1ns/1ps
`default_nettype none
module dlpr_receiver
  import dlpr_pkg::*;
(
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Odd link lane words and forwarded clock
  input  wire logic [6:0]  odd_lane0,
  input  wire logic [6:0]  odd_lane1,
  input  wire logic [6:0]  odd_lane2,
  input  wire logic [6:0]  odd_lane3,
  input  wire logic        odd_link_clock,
  // Even link lane words and forwarded clock
  input  wire logic [6:0]  even_lane0,
  input  wire logic [6:0]  even_lane1,
  input  wire logic [6:0]  even_lane2,
  input  wire logic [6:0]  even_lane3,
  input  wire logic        even_link_clock,
  // Panel pins
  input  wire logic        bit_map_select,
  input  wire logic        backlight_enable_in,
  output logic             lamp_enable_out,
  // Recovered pixel stream on the odd link clock
  output logic             pixel_valid_flag,
  output dlpr_rgb_t        odd_pixel,
  output dlpr_rgb_t        even_pixel,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata
);

  // Slot map of one link into a colour
  function automatic dlpr_rgb_t decode_rgb(input dlpr_lanes_t l);
    dlpr_rgb_t p;
    p.red   = {l.lane3[1:0], l.lane0[5:0]};
    p.green = {l.lane3[3:2], l.lane1[4:0], l.lane0[6]};
    p.blue  = {l.lane3[5:4], l.lane2[3:0], l.lane1[6], l.lane1[5]};
    return p;
  endfunction

  // Saturating counter step
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
    return (c == CNT_MAX) ? c : c + 11'h001;
  endfunction

  // Link domain reset: asserted at once, released on the link clock
  logic [1:0] lrst_ff;
  logic       link_rst;
  always_ff @(posedge odd_link_clock or posedge rst) begin
    if (rst) begin
      lrst_ff <= 2'h3;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'b0};
    end
  end
  assign link_rst = lrst_ff[1];

  // Control and map pin brought into the link domain
  logic [1:0] ctrl_ff;
  logic [2:0] lsync0_ff, lsync1_ff;
  logic       en_l, blk_l, map_l, show_l;
  always_ff @(posedge odd_link_clock or posedge link_rst) begin
    if (link_rst) begin
      lsync0_ff <= 3'h0;
      lsync1_ff <= 3'h0;
    end else begin
      lsync0_ff <= {bit_map_select, ctrl_ff[CTRL_BLACK_BIT], ctrl_ff[CTRL_EN_BIT]};
      lsync1_ff <= lsync0_ff;
    end
  end
  assign en_l   = lsync1_ff[0];
  assign blk_l  = lsync1_ff[1];
  assign map_l  = lsync1_ff[2];
  // Colours shown only when enabled, with the low map selected and no forced black
  assign show_l = en_l & ~blk_l & ~map_l;

  // Lane capture and pixel decode
  dlpr_lanes_t cap_odd_ff, cap_even_ff, nxt_cap_odd, nxt_cap_even;
  dlpr_rgb_t   odd_pix_ff, even_pix_ff, nxt_odd_pix, nxt_even_pix;
  logic        pix_valid_ff, nxt_pix_valid;
  always_comb begin
    nxt_cap_odd  = {odd_lane3, odd_lane2, odd_lane1, odd_lane0};
    nxt_cap_even = {even_lane3, even_lane2, even_lane1, even_lane0};
    nxt_pix_valid = en_l & cap_odd_ff.lane2[LANE_DE_BIT];
    nxt_odd_pix   = 24'h000000;
    nxt_even_pix  = 24'h000000;
    if (show_l) begin
      nxt_odd_pix  = decode_rgb(cap_odd_ff);
      nxt_even_pix = decode_rgb(cap_even_ff);
    end
  end
  always_ff @(posedge odd_link_clock or posedge link_rst) begin
    if (link_rst) begin
      cap_odd_ff   <= 28'h0000000;
      cap_even_ff  <= 28'h0000000;
      pix_valid_ff <= 1'b0;
      odd_pix_ff   <= 24'h000000;
      even_pix_ff  <= 24'h000000;
    end else begin
      cap_odd_ff   <= nxt_cap_odd;
      cap_even_ff  <= nxt_cap_even;
      pix_valid_ff <= nxt_pix_valid;
      odd_pix_ff   <= nxt_odd_pix;
      even_pix_ff  <= nxt_even_pix;
    end
  end
  assign pixel_valid_flag = pix_valid_ff;
  assign odd_pixel        = odd_pix_ff;
  assign even_pixel       = even_pix_ff;

  // Line and frame timing measured from data-enable alone
  logic [CNT_W-1:0] hcnt_ff, ltot_ff, gap_ff, lines_ff, last_px_ff;
  logic [CNT_W-1:0] nxt_hcnt, nxt_ltot, nxt_gap, nxt_lines, nxt_last_px;
  logic [3:0]       errs_ff, nxt_errs, errs_now;
  logic             de_q_ff, nxt_de_q, de_c, rise, fall, frame_end;
  logic             req_ff, nxt_req, idle;
  logic [1:0]       ack_s_ff;
  logic [2:0]       req_s_ff; // Request chain on the system clock
  dlpr_summary_t    payload_ff, nxt_payload;
  always_comb begin
    de_c      = cap_odd_ff.lane2[LANE_DE_BIT];
    rise      = de_c & ~de_q_ff;
    fall      = ~de_c & de_q_ff;
    frame_end = ~de_c & (gap_ff == HBLANK_MAX);
    idle      = (ack_s_ff[1] == req_ff);
    nxt_de_q  = de_c;
    nxt_hcnt  = rise ? 11'h001 : (de_c ? sat_inc(hcnt_ff) : hcnt_ff);
    nxt_ltot  = rise ? 11'h001 : sat_inc(ltot_ff);
    nxt_gap   = de_c ? 11'h000 : sat_inc(gap_ff);
    nxt_lines = fall ? sat_inc(lines_ff) : lines_ff;
    nxt_last_px = fall ? hcnt_ff : last_px_ff;
    errs_now  = errs_ff;
    if (fall && (hcnt_ff != HACTIVE)) begin
      errs_now[ERR_H_BIT] = 1'b1;
    end
    if (rise && (lines_ff != 11'h000) && (gap_ff <= HBLANK_MAX) &&
        ((ltot_ff < HTOTAL_MIN) || (ltot_ff > HTOTAL_MAX))) begin
      errs_now[ERR_T_BIT] = 1'b1;
    end
    if (de_c != cap_even_ff.lane2[LANE_DE_BIT]) begin
      errs_now[ERR_M_BIT] = 1'b1;
    end
    if (frame_end && (lines_ff != VACTIVE)) begin
      errs_now[ERR_V_BIT] = 1'b1;
    end
    nxt_errs    = errs_now;
    nxt_req     = req_ff;
    nxt_payload = payload_ff;
    if (frame_end) begin
      // Summary is dropped if the previous one is still in flight
      if (idle && (lines_ff != 11'h000)) begin
        nxt_payload.line_px     = last_px_ff;
        nxt_payload.frame_lines = lines_ff;
        nxt_payload.errs        = errs_now;
        nxt_req                 = ~req_ff;
      end
      nxt_lines = 11'h000;
      nxt_errs  = 4'h0;
    end
  end
  always_ff @(posedge odd_link_clock or posedge link_rst) begin
    if (link_rst) begin
      de_q_ff    <= 1'b0;
      hcnt_ff    <= 11'h000;
      ltot_ff    <= 11'h000;
      gap_ff     <= CNT_MAX;
      lines_ff   <= 11'h000;
      last_px_ff <= 11'h000;
      errs_ff    <= 4'h0;
      req_ff     <= 1'b0;
      payload_ff <= 26'h0000000;
      ack_s_ff   <= 2'h0;
    end else begin
      de_q_ff    <= nxt_de_q;
      hcnt_ff    <= nxt_hcnt;
      ltot_ff    <= nxt_ltot;
      gap_ff     <= nxt_gap;
      lines_ff   <= nxt_lines;
      last_px_ff <= nxt_last_px;
      errs_ff    <= nxt_errs;
      req_ff     <= nxt_req;
      payload_ff <= nxt_payload;
      ack_s_ff   <= {ack_s_ff[0], req_s_ff[2]};
    end
  end

  // Even link clock divider, watched from the system clock
  logic [EVEN_DIV_W-1:0] even_div_ff;
  always_ff @(posedge even_link_clock or posedge rst) begin
    if (rst) begin
      even_div_ff <= 5'h00;
    end else begin
      even_div_ff <= even_div_ff + 5'h01;
    end
  end

  // Pin and handshake synchronisers on the system clock
  logic [1:0] bl_s_ff, map_s_ff;
  logic [2:0] ev_s_ff;
  logic       lamp_ff, new_sum;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bl_s_ff  <= 2'h0;
      map_s_ff <= 2'h0;
      ev_s_ff  <= 3'h0;
      req_s_ff <= 3'h0;
      lamp_ff  <= 1'b0;
    end else begin
      bl_s_ff  <= {bl_s_ff[0], backlight_enable_in};
      map_s_ff <= {map_s_ff[0], bit_map_select};
      ev_s_ff  <= {ev_s_ff[1:0], even_div_ff[EVEN_DIV_W-1]};
      req_s_ff <= {req_s_ff[1:0], req_ff};
      lamp_ff  <= bl_s_ff[1];
    end
  end
  assign new_sum         = req_s_ff[2] != req_s_ff[1];
  assign lamp_enable_out = lamp_ff;

  // Register file
  logic [1:0]       nxt_ctrl;
  logic [3:0]       err_ff, nxt_err;
  logic [CNT_W-1:0] line_px_ff, frame_lines_ff, nxt_line_px, nxt_frame_lines;
  logic [15:0]      fcount_ff, nxt_fcount;
  logic [7:0]       alive_cnt_ff, nxt_alive_cnt;
  logic [31:0]      rdata_ff, nxt_rdata;
  logic [3:0]       err_clr;
  always_comb begin
    nxt_ctrl        = ctrl_ff;
    nxt_line_px     = line_px_ff;
    nxt_frame_lines = frame_lines_ff;
    nxt_fcount      = fcount_ff;
    err_clr         = 4'h0;
    if (reg_wr && (reg_addr == ADDR_CTRL)) begin
      nxt_ctrl = reg_wdata[1:0];
    end
    if (reg_wr && (reg_addr == ADDR_ERR)) begin
      err_clr = reg_wdata[3:0];
    end
    // A new error in the clearing cycle survives the clear
    nxt_err = err_ff & ~err_clr;
    if (new_sum) begin
      nxt_err         = nxt_err | payload_ff.errs;
      nxt_line_px     = payload_ff.line_px;
      nxt_frame_lines = payload_ff.frame_lines;
      nxt_fcount      = fcount_ff + 16'h0001;
    end
    // Even clock counts as alive while its divided toggle keeps moving
    if (ev_s_ff[2] != ev_s_ff[1]) begin
      nxt_alive_cnt = 8'h00;
    end else if (alive_cnt_ff != ALIVE_WIN) begin
      nxt_alive_cnt = alive_cnt_ff + 8'h01;
    end else begin
      nxt_alive_cnt = alive_cnt_ff;
    end
    nxt_rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL:   nxt_rdata = {30'h00000000, ctrl_ff};
        ADDR_STATUS: nxt_rdata = {29'h00000000, map_s_ff[1],
                                  (alive_cnt_ff != ALIVE_WIN), lamp_ff};
        ADDR_ERR:    nxt_rdata = {28'h0000000, err_ff};
        ADDR_LINE:   nxt_rdata = {21'h000000, line_px_ff};
        ADDR_FRAME:  nxt_rdata = {21'h000000, frame_lines_ff};
        ADDR_FCOUNT: nxt_rdata = {16'h0000, fcount_ff};
        default:     nxt_rdata = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff        <= CTRL_RESET;
      err_ff         <= 4'h0;
      line_px_ff     <= 11'h000;
      frame_lines_ff <= 11'h000;
      fcount_ff      <= 16'h0000;
      alive_cnt_ff   <= ALIVE_WIN;
      rdata_ff       <= 32'h00000000;
    end else begin
      ctrl_ff        <= nxt_ctrl;
      err_ff         <= nxt_err;
      line_px_ff     <= nxt_line_px;
      frame_lines_ff <= nxt_frame_lines;
      fcount_ff      <= nxt_fcount;
      alive_cnt_ff   <= nxt_alive_cnt;
      rdata_ff       <= nxt_rdata;
    end
  end
  assign reg_rdata = rdata_ff;

  // Checks on the recovered stream
  AST_ODD_RED: assert property (@(posedge odd_link_clock) disable iff (link_rst)
    show_l |=> odd_pix_ff.red[5:0] == $past(cap_odd_ff.lane0[5:0]) &&
               odd_pix_ff.green[0] == $past(cap_odd_ff.lane0[6]))
    else $error("odd lane 0 slots misplaced");
  AST_ODD_GREEN: assert property (@(posedge odd_link_clock) disable iff (link_rst)
    show_l |=> odd_pix_ff.green[5:1] == $past(cap_odd_ff.lane1[4:0]) &&
               odd_pix_ff.blue[1:0] == $past(cap_odd_ff.lane1[6:5]))
    else $error("odd lane 1 slots misplaced");
  AST_ODD_BLUE: assert property (@(posedge odd_link_clock) disable iff (link_rst)
    show_l |=> odd_pix_ff.blue[5:2] == $past(cap_odd_ff.lane2[3:0]))
    else $error("odd lane 2 slots misplaced");
  AST_ODD_HIGH: assert property (@(posedge odd_link_clock) disable iff (link_rst)
    show_l |=> {odd_pix_ff.blue[7:6], odd_pix_ff.green[7:6], odd_pix_ff.red[7:6]}
               == $past(cap_odd_ff.lane3[5:0]))
    else $error("odd lane 3 slots misplaced");
  AST_EVEN_MAP: assert property (@(posedge odd_link_clock) disable iff (link_rst)
    show_l |=> even_pix_ff.green[0] == $past(cap_even_ff.lane0[6]) &&
               even_pix_ff.blue[7] == $past(cap_even_ff.lane3[5]) &&
               even_pix_ff.blue[5:2] == $past(cap_even_ff.lane2[3:0]))
    else $error("even lanes not on the shared slot map");
  AST_PAIR: assert property (@(posedge odd_link_clock) disable iff (link_rst)
    show_l ##1 show_l |=> odd_pix_ff.red[5:0] == $past(cap_odd_ff.lane0[5:0]) &&
                         even_pix_ff.red[5:0] == $past(cap_even_ff.lane0[5:0]))
    else $error("odd and even pixels swapped");
  AST_BLACK: assert property (@(posedge odd_link_clock) disable iff (link_rst)
    !show_l |=> odd_pix_ff == 24'h000000 && even_pix_ff == 24'h000000)
    else $error("hidden pixels not black");
  AST_VALID: assert property (@(posedge odd_link_clock) disable iff (link_rst)
    en_l |=> pix_valid_ff == $past(cap_odd_ff.lane2[LANE_DE_BIT]))
    else $error("valid flag does not follow data-enable");
  AST_VALID_OFF: assert property (@(posedge odd_link_clock) disable iff (link_rst)
    !en_l |=> !pix_valid_ff)
    else $error("valid flag raised while disabled");
  AST_HACT: assert property (@(posedge odd_link_clock) disable iff (link_rst)
    fall && hcnt_ff != HACTIVE |=> errs_ff[ERR_H_BIT] || $past(frame_end))
    else $error("wrong active line length not flagged");
  AST_VACT: assert property (@(posedge odd_link_clock) disable iff (link_rst)
    frame_end && idle && lines_ff != 11'h000 && lines_ff != VACTIVE
      |=> payload_ff.errs[ERR_V_BIT] && req_ff != $past(req_ff))
    else $error("wrong active line count not reported");

endmodule
`default_nettype wire

// ---- dlpr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dlpr_host_model
  import dlpr_pkg::*;
(
  // Pixel pair to send, set by the bench on the link clock
  input  wire logic      de_odd,
  input  wire logic      de_even,
  input  wire dlpr_rgb_t px_odd,
  input  wire dlpr_rgb_t px_even,
  // Link pins
  output logic           link_clk,
  output dlpr_lanes_t    lanes_odd,
  output dlpr_lanes_t    lanes_even
);
  // One clock source feeds both links, so they stay in step
  // Runs faster than the pin limit to keep runs short; the logic has no lower period bound
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  // Slot map of one link; unused and sync slots are held low
  function automatic dlpr_lanes_t pack(input dlpr_rgb_t p, input logic de);
    pack.lane0 = {p.green[0], p.red[5:0]};
    pack.lane1 = {p.blue[1:0], p.green[5:1]};
    pack.lane2 = {de, 2'h0, p.blue[5:2]};
    pack.lane3 = {1'h0, p.blue[7:6], p.green[7:6], p.red[7:6]};
  endfunction

  // Every lane is driven at all times, odd pixel on the odd link
  assign lanes_odd  = pack(px_odd, de_odd);
  assign lanes_even = pack(px_even, de_even);
endmodule
`default_nettype wire

// ---- dual_link_pixel_receiver_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dual_link_pixel_receiver_tb;
  import dlpr_pkg::*;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        de_o    = 1'b0;
  logic        de_e    = 1'b0;
  logic        map_sel = 1'b0;
  logic        bl_en   = 1'b0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] rdata;
  dlpr_rgb_t   px_o    = '0;
  dlpr_rgb_t   px_e    = '0;
  dlpr_rgb_t   out_o;
  dlpr_rgb_t   out_e;
  dlpr_lanes_t ln_o;
  dlpr_lanes_t ln_e;
  logic        link_clk;
  logic        valid;
  logic        lamp;
  // Bench model state
  int          mismatches = 0;
  int          n_tests    = 0;
  logic [7:0]  rnd        = 8'h5F;
  logic        en         = 1'b1;
  logic        blk        = 1'b0;
  logic        chk        = 1'b0;
  logic [49:0] pexp;
  logic [49:0] pipe [$];
  logic [1:0]  ctrl;

  // System clock, 40 ns
  always #20 clk = ~clk;

  dlpr_receiver i_dut (
    .clk(clk), .rst(rst),
    .odd_lane0(ln_o.lane0), .odd_lane1(ln_o.lane1), .odd_lane2(ln_o.lane2), .odd_lane3(ln_o.lane3),
    .odd_link_clock(link_clk),
    .even_lane0(ln_e.lane0), .even_lane1(ln_e.lane1), .even_lane2(ln_e.lane2), .even_lane3(ln_e.lane3),
    .even_link_clock(link_clk),
    .bit_map_select(map_sel), .backlight_enable_in(bl_en), .lamp_enable_out(lamp),
    .pixel_valid_flag(valid), .odd_pixel(out_o), .even_pixel(out_e),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata)
  );

  dlpr_host_model i_host (
    .de_odd(de_o), .de_even(de_e), .px_odd(px_o), .px_even(px_e),
    .link_clk(link_clk), .lanes_odd(ln_o), .lanes_even(ln_e)
  );

  // Pseudo-random bytes
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Register port cycles
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    read_reg(a, v);
    check(v, exp);
  endtask

  // Poll the frame counter with a bound
  task automatic wait_frames(input logic [31:0] n);
    logic [31:0] v;
    for (int i = 0; i < 100; i++) begin
      read_reg(ADDR_FCOUNT, v);
      if (v === n) return;
    end
    check(v, n);
    final_report();
  endtask

  // Link cycles; wb sends white on odd and black on even
  task automatic send(input int n, input logic d_o, input logic d_e, input logic wb);
    logic [47:0] pix;
    repeat (n) begin
      @(posedge link_clk);
      for (int i = 0; i < 6; i++) begin
        rnd = lfsr(rnd);
        pix = {pix[39:0], rnd};
      end
      de_o <= d_o;
      de_e <= d_e;
      px_o <= wb ? 24'hFFFFFF : (d_o ? pix[47:24] : 24'h0);
      px_e <= wb ? 24'h000000 : (d_o ? pix[23:0] : 24'h0);
    end
  endtask

  // One line; bad raises only the even data-enable once in blanking
  task automatic send_line(input int act, input int blank, input logic bad);
    send(1, 1'b1, 1'b1, 1'b1);
    send(act - 1, 1'b1, 1'b1, 1'b0);
    send(1, 1'b0, bad, 1'b0);
    send(blank - 1, 1'b0, 1'b0, 1'b0);
  endtask

  // Reference pipeline: output shows two link edges after the lanes are taken
  always @(posedge link_clk) begin
    pipe.push_back({chk, de_o, px_o, px_e});
    if (pipe.size() > 2) begin
      pexp = pipe.pop_front();
      pexp[47:0] = (en & !blk & !map_sel) ? pexp[47:0] : 48'h0;
      if (pexp[49]) check({valid, out_o, out_e}, {pexp[48] & en, pexp[47:0]});
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check_reg(ADDR_CTRL, 32'h1);
    check_reg(ADDR_ERR, 32'h0);
    check_reg(ADDR_FCOUNT, 32'h0);
    write_reg(8'h18, 32'hFFFFFFFF);
    check_reg(8'h18, 32'h0);
    // Lamp follows the enable once logic runs
    bl_en <= 1'b1;
    repeat (5) @(posedge clk);
    check(lamp, 1'b1);
    // A two-line frame of well-formed lines, flagged for its short line count
    chk <= 1'b1;
    send_line(640, 100, 1'b0);
    send_line(640, 100, 1'b0);
    send(330, 1'b0, 1'b0, 1'b0);
    chk <= 1'b0;
    wait_frames(32'h1);
    check_reg(ADDR_STATUS, 32'h3);
    check_reg(ADDR_LINE, 32'h280);
    check_reg(ADDR_FRAME, 32'h2);
    check_reg(ADDR_ERR, 32'h4);
    write_reg(ADDR_ERR, 32'h4);
    check_reg(ADDR_ERR, 32'h0);
    // Short line total, short line, data-enable copies apart
    send_line(640, 50, 1'b0);
    send_line(639, 101, 1'b1);
    send(330, 1'b0, 1'b0, 1'b0);
    wait_frames(32'h2);
    check_reg(ADDR_LINE, 32'h27F);
    check_reg(ADDR_FRAME, 32'h2);
    check_reg(ADDR_ERR, 32'hF);
    write_reg(ADDR_ERR, 32'hF);
    check_reg(ADDR_ERR, 32'h0);
    // Output modes: black, disabled, unsupported map, normal
    for (int m = 0; m < 4; m++) begin
      ctrl = (m == 0) ? 2'h3 : (m == 1) ? 2'h0 : 2'h1;
      write_reg(ADDR_CTRL, {30'h0, ctrl});
      map_sel <= (m == 2);
      en      <= ctrl[0];
      blk     <= ctrl[1];
      check_reg(ADDR_CTRL, {30'h0, ctrl});
      send_line(16, 8, 1'b0);
      chk <= 1'b1;
      send_line(16, 8, 1'b0);
      send_line(16, 8, 1'b0);
      chk <= 1'b0;
      check_reg(ADDR_STATUS, {29'h0, map_sel, 2'h3});
    end
    // Lamp off before logic stops
    bl_en <= 1'b0;
    repeat (5) @(posedge clk);
    check(lamp, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
